// >>> fdp_pkg.sv
`default_nettype none
package fdp_pkg;
  // i/o register addresses
  localparam logic [7:0] KEY_ADDR   = 8'hf5;
  localparam logic [7:0] FDIV_ADDR  = 8'hf9;
  localparam logic [7:0] PROT_ADDR  = 8'hfa;
  localparam logic [7:0] IRQ_ADDR   = 8'hfb;
  localparam logic [7:0] PAGE_ADDR  = 8'hfc;
  localparam logic [7:0] PGCTL_ADDR = 8'hff;
  // unlock key sequence
  localparam logic [7:0] KEY_FIRST  = 8'hb6;
  localparam logic [7:0] KEY_SECOND = 8'h49;
  // reset values
  localparam logic [7:0] FDIV_RESET = 8'h01;
  localparam logic [7:0] PROT_RESET = 8'hff;
  localparam logic [7:0] PROT_ALL   = 8'hff;
  // irq control/status fields
  localparam int DONE_IRQ_EN_BIT = 7;
  localparam int ERR_IRQ_EN_BIT  = 6;
  localparam int DONE_BIT        = 5;
  localparam int WRITE_VIOL_BIT  = 3;
  localparam int TMO_BIT         = 2;
  localparam int PAGE_VIOL_BIT   = 1;
  localparam int MASS_VIOL_BIT   = 0;
  // page register info-page select, program control row bit
  localparam int INFO_EN_BIT     = 7;
  localparam int ROW_PROG_BIT    = 2;
  // flash geometry: 8 blocks of 32 KB, 18-bit address
  localparam int ADDR_W       = 18;
  localparam int BLK_LSB      = 15;
  localparam int NUM_BLK      = 8;
  // flash clock period window and row-program timeout
  localparam real FCLK_MIN_US   = 5.1;
  localparam real FCLK_MAX_US   = 6.5;
  localparam int  SYS_CLK_MHZ   = 50;
  localparam logic [12:0] ROW_TMO_FCLKS = 13'd4864;
  // unlock state machine
  typedef enum logic [2:0] {
    KS_LOCKED = 3'b001,
    KS_HALF   = 3'b010,
    KS_OPEN   = 3'b100
  } fdp_key_e;
endpackage
`default_nettype wire

// >>> fdp_clk_div.sv
`default_nettype none
// flash controller clock enable: one pulse every divide cycles
module fdp_clk_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // divider setting
  input  wire logic [7:0] divide,
  // enable pulse
  output logic            tick
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (cnt_reg + 8'h01 >= divide) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> fdp_flash_ctl.sv
`default_nettype none
// Function
// - flash clock is system clock over divider
// - divider is 8 bits, resets to one
// - divider writable only after unlock
// - key writes b6 then 49 unlock both
// - locked protect write forces all ones
// - protect bit n guards 32 KB block n
// - all blocks protected after reset
// - boot block protected by pin or bit
// - info page erased only if selected
// - row program stops after 4864 flash clocks
// - protected write refused, write violation set
// - protected page erase refused, violation set
// - mass erase refused if any protection
// - pin blocks boot page and mass erase
// - done flag on erase or row program success, irq if enabled
// - error flags raise irq if enabled
// - irq register read clears flags only
module fdp_flash_ctl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // i/o register port
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  // write-protect pin
  input  wire logic        write_protect_n,
  // flash array requests
  input  wire logic        write_req,
  input  wire logic [17:0] write_addr,
  input  wire logic        write_done,
  input  wire logic        page_erase_req,
  input  wire logic [17:0] page_erase_addr,
  input  wire logic        page_erase_done,
  input  wire logic        mass_erase_req,
  input  wire logic        mass_erase_done,
  input  wire logic        row_program_done,
  // grants and controls
  output logic             write_grant,
  output logic             page_erase_grant,
  output logic             mass_erase_grant,
  output logic             mass_erase_info,
  output logic             row_program_request,
  output logic             flash_clk_tick,
  output logic             irq
);
  logic [7:0]        flash_clock_divider_reg;
  logic [7:0]        block_protect_bits_reg;
  logic [7:0]        irq_reg;
  logic [7:0]        page_reg;
  logic [12:0]       tmo_reg;
  logic              tick;
  logic              unlocked;
  logic              wp_active;
  logic [7:0]        eff_prot;
  fdp_pkg::fdp_key_e key_reg;
  fdp_pkg::fdp_key_e key_next;

  // block index of an 18-bit flash address
  function automatic logic [2:0] blk_of(input logic [17:0] a);
    blk_of = a[fdp_pkg::ADDR_W-1:fdp_pkg::BLK_LSB];
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = io_wr && (io_addr == a);
  endfunction

  fdp_clk_div u_div (
    .clk    (clk),
    .rst    (rst),
    .divide (flash_clock_divider_reg),
    .tick   (tick)
  );

  assign unlocked  = (key_reg == fdp_pkg::KS_OPEN);
  assign wp_active = ~write_protect_n;

  // effective protection, pin or-ed into boot block
  genvar g;
  generate
    for (g = 0; g < fdp_pkg::NUM_BLK; g++) begin : g_prot
      if (g == 0) begin : g_boot
        assign eff_prot[g] = block_protect_bits_reg[g] | wp_active;
      end else begin : g_other
        assign eff_prot[g] = block_protect_bits_reg[g];
      end
    end
  endgenerate

  // unlock sequence; other register writes relock, except divider and protect writes while open
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      fdp_pkg::KS_LOCKED: begin
        if (wr_hit(fdp_pkg::KEY_ADDR) && io_wdata == fdp_pkg::KEY_FIRST)
          key_next = fdp_pkg::KS_HALF;
      end
      fdp_pkg::KS_HALF: begin
        if (io_wr) begin
          if (io_addr == fdp_pkg::KEY_ADDR && io_wdata == fdp_pkg::KEY_SECOND)
            key_next = fdp_pkg::KS_OPEN;
          else if (io_addr == fdp_pkg::KEY_ADDR && io_wdata == fdp_pkg::KEY_FIRST)
            key_next = fdp_pkg::KS_HALF;
          else
            key_next = fdp_pkg::KS_LOCKED;
        end
      end
      // a fresh first key restarts the sequence instead of dropping it
      fdp_pkg::KS_OPEN: begin
        if (wr_hit(fdp_pkg::KEY_ADDR) && io_wdata == fdp_pkg::KEY_FIRST)
          key_next = fdp_pkg::KS_HALF;
        else if (io_wr && io_addr != fdp_pkg::FDIV_ADDR && io_addr != fdp_pkg::PROT_ADDR)
          key_next = fdp_pkg::KS_LOCKED;
      end
      default: key_next = fdp_pkg::KS_LOCKED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) key_reg <= fdp_pkg::KS_LOCKED;
    else     key_reg <= key_next;
  end

  always_ff @(posedge clk) begin
    if (rst)
      flash_clock_divider_reg <= fdp_pkg::FDIV_RESET;
    else if (wr_hit(fdp_pkg::FDIV_ADDR) && unlocked && io_wdata != 8'h00)
      flash_clock_divider_reg <= io_wdata;
  end

  always_ff @(posedge clk) begin
    if (rst)
      block_protect_bits_reg <= fdp_pkg::PROT_RESET;
    else if (wr_hit(fdp_pkg::PROT_ADDR))
      block_protect_bits_reg <= unlocked ? io_wdata : fdp_pkg::PROT_ALL;
  end

  always_ff @(posedge clk) begin
    if (rst) page_reg <= 8'h00;
    else if (wr_hit(fdp_pkg::PAGE_ADDR)) page_reg <= io_wdata;
  end

  // row program with timeout counted in flash clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      row_program_request <= 1'b0;
      tmo_reg             <= 13'd0;
    end else if (wr_hit(fdp_pkg::PGCTL_ADDR)) begin
      row_program_request <= io_wdata[fdp_pkg::ROW_PROG_BIT];
      tmo_reg             <= 13'd0;
    end else if (row_program_request) begin
      if (row_program_done) begin
        row_program_request <= 1'b0;
      end else if (tick) begin
        if (tmo_reg + 13'd1 >= fdp_pkg::ROW_TMO_FCLKS)
          row_program_request <= 1'b0;
        tmo_reg <= tmo_reg + 13'd1;
      end
    end
  end

  logic tmo_evt;
  assign tmo_evt = row_program_request && !row_program_done && tick &&
                   (tmo_reg + 13'd1 >= fdp_pkg::ROW_TMO_FCLKS) &&
                   !wr_hit(fdp_pkg::PGCTL_ADDR);

  logic write_violation_flag_evt;
  logic page_erase_violation_flag_evt;
  logic mass_erase_violation_flag_evt;
  logic done_evt;
  logic info_sel;
  assign info_sel     = page_reg[fdp_pkg::INFO_EN_BIT];
  assign write_violation_flag_evt   = write_req && eff_prot[blk_of(write_addr)];
  assign page_erase_violation_flag_evt   = page_erase_req && !info_sel &&
                        eff_prot[blk_of(page_erase_addr)];
  assign mass_erase_violation_flag_evt = mass_erase_req && (|eff_prot);
  assign done_evt     = page_erase_done || mass_erase_done ||
                        (row_program_done && row_program_request);

  // grants go only to unprotected requests
  always_ff @(posedge clk) begin
    if (rst) begin
      write_grant      <= 1'b0;
      page_erase_grant <= 1'b0;
      mass_erase_grant <= 1'b0;
      mass_erase_info  <= 1'b0;
    end else begin
      write_grant      <= write_req && !write_violation_flag_evt;
      page_erase_grant <= page_erase_req && !page_erase_violation_flag_evt;
      mass_erase_grant <= mass_erase_req && !mass_erase_violation_flag_evt;
      mass_erase_info  <= info_sel;
    end
  end

  // flags: set beats read-clear, enables kept
  logic rd_irq;
  logic [7:0] set_bits;
  assign rd_irq = io_rd && (io_addr == fdp_pkg::IRQ_ADDR);
  always_comb begin
    set_bits = 8'h00;
    set_bits[fdp_pkg::DONE_BIT]     = done_evt;
    set_bits[fdp_pkg::WRITE_VIOL_BIT] = write_violation_flag_evt;
    set_bits[fdp_pkg::TMO_BIT]        = tmo_evt;
    set_bits[fdp_pkg::PAGE_VIOL_BIT]  = page_erase_violation_flag_evt;
    set_bits[fdp_pkg::MASS_VIOL_BIT]  = mass_erase_violation_flag_evt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 8'h00;
    end else begin
      if (wr_hit(fdp_pkg::IRQ_ADDR)) begin
        irq_reg[fdp_pkg::DONE_IRQ_EN_BIT] <= io_wdata[fdp_pkg::DONE_IRQ_EN_BIT];
        irq_reg[fdp_pkg::ERR_IRQ_EN_BIT]  <= io_wdata[fdp_pkg::ERR_IRQ_EN_BIT];
      end
      irq_reg[5:0] <= (rd_irq ? 6'h00 : irq_reg[5:0]) | set_bits[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) irq <= 1'b0;
    else irq <= (irq_reg[fdp_pkg::DONE_IRQ_EN_BIT] && irq_reg[fdp_pkg::DONE_BIT]) ||
                (irq_reg[fdp_pkg::ERR_IRQ_EN_BIT] && (|irq_reg[3:0]));
  end

  always_ff @(posedge clk) begin
    if (rst) flash_clk_tick <= 1'b0;
    else flash_clk_tick <= tick;
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) io_rdata <= 8'h00;
    else if (io_rd) begin
      case (io_addr)
        fdp_pkg::FDIV_ADDR:  io_rdata <= flash_clock_divider_reg;
        fdp_pkg::PROT_ADDR:  io_rdata <= block_protect_bits_reg;
        fdp_pkg::IRQ_ADDR:   io_rdata <= {irq_reg[7:5], 1'b0, irq_reg[3:0]};
        fdp_pkg::PAGE_ADDR:  io_rdata <= page_reg;
        fdp_pkg::PGCTL_ADDR: io_rdata <= {5'h00, row_program_request, 2'b00};
        default:             io_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  a_prot_locked: assert property (@(posedge clk) disable iff (rst)
    wr_hit(fdp_pkg::PROT_ADDR) && !unlocked |=> block_protect_bits_reg == fdp_pkg::PROT_ALL)
    else $error("locked protect write did not force all ones");
  a_fdiv_locked: assert property (@(posedge clk) disable iff (rst)
    wr_hit(fdp_pkg::FDIV_ADDR) && !unlocked |=> $stable(flash_clock_divider_reg))
    else $error("divider changed while locked");
  a_key_open: assert property (@(posedge clk) disable iff (rst)
    wr_hit(fdp_pkg::KEY_ADDR) && io_wdata == fdp_pkg::KEY_FIRST ##1 !io_wr ##1
    wr_hit(fdp_pkg::KEY_ADDR) && io_wdata == fdp_pkg::KEY_SECOND |=> unlocked)
    else $error("key sequence did not unlock");
  a_boot_pin: assert property (@(posedge clk) disable iff (rst)
    wp_active && mass_erase_req |=> irq_reg[fdp_pkg::MASS_VIOL_BIT] && !mass_erase_grant)
    else $error("mass erase passed with pin asserted");
  a_write_violation_flag: assert property (@(posedge clk) disable iff (rst)
    write_req && block_protect_bits_reg[blk_of(write_addr)] |=>
    !write_grant && irq_reg[fdp_pkg::WRITE_VIOL_BIT])
    else $error("protected write not refused");
  a_page_erase_violation_flag: assert property (@(posedge clk) disable iff (rst)
    page_erase_req && !info_sel && block_protect_bits_reg[blk_of(page_erase_addr)] |=>
    !page_erase_grant && irq_reg[fdp_pkg::PAGE_VIOL_BIT])
    else $error("protected page erase not refused");
  a_rd_clear: assert property (@(posedge clk) disable iff (rst)
    rd_irq && set_bits == 8'h00 && !wr_hit(fdp_pkg::IRQ_ADDR) |=>
    irq_reg[5:0] == 6'h00 && $stable(irq_reg[7:6]))
    else $error("irq read did not clear flags");
  a_irq_err: assert property (@(posedge clk) disable iff (rst)
    irq_reg[fdp_pkg::ERR_IRQ_EN_BIT] && irq_reg[fdp_pkg::WRITE_VIOL_BIT] |=> irq)
    else $error("error flag did not raise irq");
  a_tmo_stop: assert property (@(posedge clk) disable iff (rst)
    tmo_evt |=> !row_program_request && irq_reg[fdp_pkg::TMO_BIT])
    else $error("row program timeout not handled");
  c_unlock:   cover property (@(posedge clk) disable iff (rst) unlocked);
  c_timeout:  cover property (@(posedge clk) disable iff (rst) tmo_evt);
  c_done_irq: cover property (@(posedge clk) disable iff (rst) done_evt ##2 irq);
endmodule
`default_nettype wire

// >>> fdp_flash_model.sv
`default_nettype none
// flash array stand-in: answers each grant after 1 or 8 cycles
module fdp_flash_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // controller side
  input  wire logic write_grant,
  input  wire logic page_erase_grant,
  input  wire logic mass_erase_grant,
  input  wire logic row_program_request,
  // pacing
  input  wire logic slow,
  input  wire logic stall_row,
  // completions
  output logic      write_done,
  output logic      page_erase_done,
  output logic      mass_erase_done,
  output logic      row_program_done
);
  logic [2:0] kind_reg;
  logic [3:0] cnt_reg;
  logic [3:0] row_cnt_reg;
  always_ff @(posedge clk) begin
    {write_done, page_erase_done, mass_erase_done, row_program_done} <= 4'h0;
    if (rst) begin
      kind_reg <= 3'h0;
      cnt_reg <= 4'h0;
      row_cnt_reg <= 4'h0;
    end else begin
      if (write_grant | page_erase_grant | mass_erase_grant) begin
        kind_reg <= {write_grant, page_erase_grant, mass_erase_grant};
        cnt_reg <= slow ? 4'h8 : 4'h1;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) {write_done, page_erase_done, mass_erase_done} <= kind_reg;
      end
      // stalled row never finishes, so the controller must time it out
      if (!row_program_request) row_cnt_reg <= 4'h0;
      else if (!stall_row && row_cnt_reg != 4'hf) begin
        row_cnt_reg <= row_cnt_reg + 4'h1;
        if (row_cnt_reg == (slow ? 4'h8 : 4'h2)) row_program_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
`define chk(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, io_wr, io_rd, write_protect_n, slow, stall_row, g;
  logic [7:0]  io_addr, io_wdata, io_rdata;
  logic [17:0] write_addr, page_erase_addr;
  logic        write_req, page_erase_req, mass_erase_req, write_done;
  logic        page_erase_done, mass_erase_done, row_program_done;
  logic        write_grant, page_erase_grant, mass_erase_grant;
  logic        mass_erase_info, row_program_request, flash_clk_tick, irq;
  int          errors, checks_done, n;

  fdp_flash_ctl u_dut (.clk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .write_protect_n, .write_req, .write_addr, .write_done, .page_erase_req,
    .page_erase_addr, .page_erase_done, .mass_erase_req, .mass_erase_done,
    .row_program_done, .write_grant, .page_erase_grant, .mass_erase_grant,
    .mass_erase_info, .row_program_request, .flash_clk_tick, .irq);
  fdp_flash_model u_flash (.clk, .rst, .write_grant, .page_erase_grant,
    .mass_erase_grant, .row_program_request, .slow, .stall_row, .write_done,
    .page_erase_done, .mass_erase_done, .row_program_done);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk) #1;
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk) #1;
    io_rd = 1'b0;
    `chk($sformatf("reg %h", a), e, io_rdata)
  endtask
  task automatic unlock();
    wr(fdp_pkg::KEY_ADDR, fdp_pkg::KEY_FIRST);
    wr(fdp_pkg::KEY_ADDR, fdp_pkg::KEY_SECOND);
  endtask
  // kind 0 write, 1 page erase, 2 mass erase; returns the grant seen
  task automatic req(input int k, input logic [17:0] a, output logic gr);
    @(posedge clk) #1;
    write_addr = a;
    page_erase_addr = a;
    write_req = (k == 0);
    page_erase_req = (k == 1);
    mass_erase_req = (k == 2);
    @(posedge clk) #1;
    {write_req, page_erase_req, mass_erase_req} = 3'h0;
    gr = (k == 0) ? write_grant : (k == 1) ? page_erase_grant : mass_erase_grant;
  endtask
  task automatic tick_gap(output int c);
    c = 0;
    while (flash_clk_tick !== 1'b1 && c < 600) begin
      idle(1);
      c++;
    end
    c = 0;
    do begin
      idle(1);
      c++;
    end while (flash_clk_tick !== 1'b1 && c < 600);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(20000 * 20);
    errors++;
    conclude();
  end

  initial begin
    {rst, io_wr, io_rd, write_req, page_erase_req, mass_erase_req} = 6'h20;
    {io_addr, io_wdata, write_addr, page_erase_addr} = '0;
    {write_protect_n, slow, stall_row} = 3'b100;
    idle(10);
    rst = 1'b0;
    rd(fdp_pkg::FDIV_ADDR, 8'h01);
    rd(fdp_pkg::PROT_ADDR, 8'hff);
    rd(fdp_pkg::IRQ_ADDR, 8'h00);
    wr(fdp_pkg::FDIV_ADDR, 8'h05);
    rd(fdp_pkg::FDIV_ADDR, 8'h01);
    unlock();
    wr(fdp_pkg::PROT_ADDR, 8'h00);
    rd(fdp_pkg::PROT_ADDR, 8'h00);
    wr(fdp_pkg::PAGE_ADDR, 8'h00);
    wr(fdp_pkg::PROT_ADDR, 8'h0f);
    rd(fdp_pkg::PROT_ADDR, 8'hff);
    wr(fdp_pkg::KEY_ADDR, fdp_pkg::KEY_FIRST);
    wr(fdp_pkg::KEY_ADDR, 8'h12);
    wr(fdp_pkg::FDIV_ADDR, 8'h07);
    rd(fdp_pkg::FDIV_ADDR, 8'h01);
    $display("test lock done");
    // ceiling of 50 MHz times 5.1 us
    unlock();
    wr(fdp_pkg::FDIV_ADDR, 8'hff);
    tick_gap(n);
    tick_gap(n);
    `chk("tick gap", 255, n)
    unlock();
    wr(fdp_pkg::FDIV_ADDR, 8'h00);
    rd(fdp_pkg::FDIV_ADDR, 8'hff);
    $display("test divider done");
    for (int b = 0; b < 8; b++) begin
      unlock();
      wr(fdp_pkg::PROT_ADDR, 8'h01 << b);
      req(0, 18'((b + 1) * 32768 - 1), g);
      `chk("write grant", 1'b0, g)
      req(1, 18'(b * 32768), g);
      `chk("page grant", 1'b0, g)
      req(2, 18'h0, g);
      `chk("mass grant", 1'b0, g)
      req(0, 18'(((b + 1) % 8) * 32768), g);
      `chk("write grant", 1'b1, g)
      rd(fdp_pkg::IRQ_ADDR, 8'h0b);
    end
    $display("test blocks done");
    unlock();
    wr(fdp_pkg::PROT_ADDR, 8'h00);
    write_protect_n = 1'b0;
    slow = 1'b1;
    req(1, 18'h0, g);
    `chk("boot page grant", 1'b0, g)
    req(2, 18'h0, g);
    `chk("mass grant", 1'b0, g)
    req(1, 18'h08000, g);
    `chk("page grant", 1'b1, g)
    idle(12);
    rd(fdp_pkg::IRQ_ADDR, 8'h23);
    wr(fdp_pkg::PAGE_ADDR, 8'h80);
    idle(2);
    `chk("info", 1'b1, mass_erase_info)
    req(1, 18'h0, g);
    `chk("info page grant", 1'b1, g)
    idle(12);
    rd(fdp_pkg::IRQ_ADDR, 8'h20);
    $display("test pin done");
    slow = 1'b0;
    wr(fdp_pkg::IRQ_ADDR, 8'h40);
    req(2, 18'h0, g);
    idle(1);
    `chk("irq", 1'b1, irq)
    rd(fdp_pkg::IRQ_ADDR, 8'h41);
    idle(1);
    `chk("irq", 1'b0, irq)
    wr(fdp_pkg::IRQ_ADDR, 8'h80);
    req(2, 18'h0, g);
    idle(1);
    `chk("irq", 1'b0, irq)
    write_protect_n = 1'b1;
    req(2, 18'h0, g);
    `chk("mass grant", 1'b1, g)
    idle(6);
    `chk("irq", 1'b1, irq)
    rd(fdp_pkg::IRQ_ADDR, 8'ha1);
    $display("test irq done");
    unlock();
    wr(fdp_pkg::FDIV_ADDR, 8'h01);
    stall_row = 1'b1;
    wr(fdp_pkg::PGCTL_ADDR, 8'h04);
    n = 0;
    while (row_program_request === 1'b1 && n < 6000) begin
      idle(1);
      n++;
    end
    `chk("row length ok", 1'b1, n >= 4863 && n <= 4867)
    rd(fdp_pkg::IRQ_ADDR, 8'h84);
    stall_row = 1'b0;
    wr(fdp_pkg::PGCTL_ADDR, 8'h04);
    idle(10);
    `chk("row request", 1'b0, row_program_request)
    rd(fdp_pkg::IRQ_ADDR, 8'ha0);
    $display("test row done");
    conclude();
  end
endmodule
`default_nettype wire
